// File: logic/jtd_tap.sv
// Boundary-scan test access port with inner chip TAP, debug sync pin and boot gating
`timescale 1ns/10ps

// Operation
// RULE1 - One standard TAP, supporting boundary scan of the I/O pins.
// RULE2 - Instruction register is four bits; data path is thirty-two bits.
// RULE3 - A dedicated instruction connects the host through to the inner chip TAP.
// RULE4 - Host holds TAP reset low during power-up and 100 ns after.
// RULE5 - TAP reset held low keeps the test logic in reset indefinitely.
// RULE6 - Debug pin floats, and is driven low on breakpoint when output is enabled.
// RULE7 - Debug pin pulled low puts tile into debug when input is enabled.
// RULE8 - DEVICE_IDENTIFICATION_WORD shifts version, part number, maker identity and a one in bit 0.
// RULE9 - USERCODE returns user ID, unused field and silicon revision.
// RULE10 - Global reset asserts asynchronously and resets everything regardless of clock.
// RULE11 - After global reset release, wait for PLL lock before booting.
// RULE12 - System holds global reset low during power-up and 100 ns after; the bench releases it at 20 ns.
// RULE13 - Security bit 0 set disables the test port completely.
// RULE14 - User ID comes from security bits 31 to 22, loaded at power-up.
// RULE15 - Sixteen-state controller; TMS taken on TCK rise, TDO changes on fall.
module jtd_tap import jtd_pkg::*; #(
  parameter int BSC_N = 8,
  parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h0abc, // Arbitrary value
  parameter logic [10:0] ID_MFR = 11'h123, // Arbitrary value
  parameter logic [UC_REV_W-1:0] SI_REV = 16'h0001, // Arbitrary value
  parameter int BOOT_MODE_W = 3
) (
  // Clock and global reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Test port pins from the host
  input wire jtd_pins_t pins_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Inner chip TAP
  output jtd_inner_t inner_out,
  input wire logic inner_tdo_in,
  // Boundary-scanned I/O
  input wire logic [BSC_N-1:0] core_out_in,
  input wire logic [BSC_N-1:0] pad_in,
  output logic [BSC_N-1:0] pad_out,
  // Debug synchronisation pin and tile side
  input wire logic dbg_pin_in,
  output logic dbg_pin_out,
  output logic dbg_pin_oe_out,
  input wire logic dbg_out_en_in,
  input wire logic dbg_in_en_in,
  input wire logic breakpoint_in,
  output logic debug_req_out,
  // Security word from one-time memory and boot control
  input wire logic [31:0] sec_word_in,
  input wire logic pll_lock_in,
  input wire logic [BOOT_MODE_W-1:0] boot_mode_in,
  output logic boot_go_out,
  output logic [BOOT_MODE_W-1:0] boot_mode_out
);

  localparam int SYN_W = 7 + BSC_N;
  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  // Debug pin rests high behind its pull-up, so its flops start high to avoid a false request
  localparam logic [SYN_W-1:0] SYN_RST = SYN_W'(8'h10);

  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic tck_d;
  logic [31:0] sec;
  logic sec_loaded;
  jtd_state_t state;
  jtd_state_t next_state;
  logic [IR_W-1:0] ir;
  logic [IR_W-1:0] ir_sh;
  logic [DR_W-1:0] dr_sh;
  logic byp;
  logic [BSC_N-1:0] bsr;
  logic [BSC_N-1:0] bsu;
  logic boot_go;

  // Every pin input passes two flops before anything reads it
  wire [SYN_W-1:0] raw = {pad_in, pll_lock_in, inner_tdo_in, dbg_pin_in,
                          pins_in.tck, pins_in.tms, pins_in.tdi, pins_in.trst_n};
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= SYN_RST;
      sync2 <= SYN_RST;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Named views of the synchronised pins
  wire trst_s = sync2[0];
  wire tdi_s = sync2[1];
  wire tms_s = sync2[2];
  wire tck_s = sync2[3];
  wire dbg_s = sync2[4];
  wire itdo_s = sync2[5];
  wire pll_s = sync2[6];
  wire [BSC_N-1:0] pad_s = sync2[SYN_W-1:7];

  // TCK edge detection on the system clock
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  // Security word is taken once after reset release; port stays off until then
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec <= SEC_RESET;
      sec_loaded <= 1'b0;
    end else if (!sec_loaded) begin
      sec <= sec_word_in; // RULE14
      sec_loaded <= 1'b1;
    end
  end

  // Test logic held in reset by the pin, the lock bit or an unloaded security word
  wire test_off = sec[SEC_TEST_OFF] | ~sec_loaded; // RULE13
  wire tap_rst = ~trst_s | test_off; // RULE5

  // Standard state transitions
  always_comb begin
    case (state)
      TS_RESET: next_state = tms_s ? TS_RESET : TS_IDLE;
      TS_IDLE: next_state = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: next_state = tms_s ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: next_state = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: next_state = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: next_state = tms_s ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: next_state = tms_s ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: next_state = tms_s ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: next_state = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: next_state = tms_s ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: next_state = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: next_state = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: next_state = tms_s ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: next_state = tms_s ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: next_state = tms_s ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: next_state = tms_s ? TS_SEL_DR : TS_IDLE;
      default: next_state = TS_RESET;
    endcase
  end

  // Controller advances only on a TCK rise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= TS_RESET;
    end else if (tap_rst) begin
      state <= TS_RESET;
    end else if (tck_rise) begin
      state <= next_state; // RULE15
    end
  end

  // Instruction decode
  wire sel_id = (ir == INS_DEVICE_IDENTIFICATION_WORD);
  wire sel_uc = (ir == INS_USERCODE);
  wire sel_bs = (ir == INS_EXTEST) | (ir == INS_SAMPLE);
  wire sel_chip = (ir == INS_CHIPTAP);
  wire sel_word = sel_id | sel_uc;
  wire [31:0] uc_word = {sec[31:SEC_UID_LSB], {(32 - UC_UID_W - UC_REV_W){1'b0}}, SI_REV};

  // Instruction shifter and latch; reset selects the identification word
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ir <= INS_DEVICE_IDENTIFICATION_WORD;
      ir_sh <= IR_CAPTURE;
    end else if (tap_rst || state == TS_RESET) begin
      ir <= INS_DEVICE_IDENTIFICATION_WORD; // RULE1
    end else if (tck_rise) begin
      case (state)
        TS_CAP_IR: ir_sh <= IR_CAPTURE;
        TS_SH_IR: ir_sh <= {tdi_s, ir_sh[IR_W-1:1]}; // RULE2
        TS_UPD_IR: ir <= ir_sh;
        default: ir_sh <= ir_sh;
      endcase
    end
  end

  // Word, bypass and boundary shifters
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dr_sh <= '0;
      byp <= 1'b0;
      bsr <= '0;
    end else if (tck_rise && state == TS_CAP_DR) begin
      dr_sh <= sel_id ? ID_WORD : (sel_uc ? uc_word : '0); // RULE8 RULE9
      byp <= 1'b0;
      bsr <= pad_s; // RULE1
    end else if (tck_rise && state == TS_SH_DR) begin
      dr_sh <= {tdi_s, dr_sh[DR_W-1:1]}; // RULE2
      byp <= tdi_s;
      bsr <= {tdi_s, bsr[BSC_N-1:1]};
    end
  end

  // Boundary update register steers the pads under EXTEST
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bsu <= '0;
    end else if (tck_rise && state == TS_UPD_DR && sel_bs) begin
      bsu <= bsr;
    end
  end

  // Pads follow the core unless EXTEST holds them
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pad_out <= '0;
    end else begin
      pad_out <= (ir == INS_EXTEST && !tap_rst) ? bsu : core_out_in; // RULE1
    end
  end

  // Serial output source
  wire shifting = (state == TS_SH_DR) | (state == TS_SH_IR);
  wire dr_bit = sel_word ? dr_sh[0] : (sel_bs ? bsr[0] : (sel_chip ? itdo_s : byp)); // RULE3
  wire tdo_src = (state == TS_SH_IR) ? ir_sh[0] : dr_bit;

  // TDO moves only on a TCK fall, which gives the host a half period of setup less the synchroniser delay
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tap_rst) begin
      tdo_oe_out <= 1'b0; // RULE5 RULE13
    end else if (tck_fall) begin
      tdo_out <= tdo_src; // RULE15
      tdo_oe_out <= shifting;
    end
  end

  // Inner TAP sees host TCK and TMS only while selected, TDI always; its TMS rests high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      inner_out <= '{sel: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    end else begin
      inner_out.sel <= sel_chip & ~tap_rst; // RULE3
      inner_out.tck <= sel_chip & ~tap_rst & tck_s;
      inner_out.tms <= (sel_chip & ~tap_rst) ? tms_s : 1'b1;
      inner_out.tdi <= tdi_s;
    end
  end

  // Debug pin is open drain: only ever pulled low, otherwise left floating
  wire dbg_ok = ~sec[SEC_DBG_OFF] & sec_loaded;
  assign dbg_pin_out = 1'b0; // RULE6
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_pin_oe_out <= 1'b0;
      debug_req_out <= 1'b0;
    end else begin
      dbg_pin_oe_out <= dbg_ok & dbg_out_en_in & breakpoint_in; // RULE6
      debug_req_out <= dbg_ok & dbg_in_en_in & ~dbg_s; // RULE7
    end
  end

  // Boot starts only once the PLL reports lock after reset release
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_go <= 1'b0; // RULE10
      boot_mode_out <= '0;
    end else if (!boot_go && pll_s) begin
      boot_go <= 1'b1; // RULE11
      boot_mode_out <= boot_mode_in;
    end
  end
  assign boot_go_out = boot_go;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  trst_hold_a: assert property (!trst_s |=> state == TS_RESET) // RULE5
    else $error("TAP left reset while TRST low");
  sec_off_a: assert property (sec[SEC_TEST_OFF] && sec_loaded |=> !tdo_oe_out && state == TS_RESET) // RULE13
    else $error("Test port active while locked");
  id_capture_a: assert property (tck_rise && !tap_rst && state == TS_CAP_DR && sel_id |=> dr_sh == ID_WORD && dr_sh[0]) // RULE8
    else $error("Identification word wrong");
  uc_capture_a: assert property (tck_rise && !tap_rst && state == TS_CAP_DR && sel_uc
    |=> dr_sh[31:UC_UID_LSB] == sec[31:SEC_UID_LSB] && dr_sh[UC_REV_W-1:0] == SI_REV) // RULE9
    else $error("User code word wrong");
  ir_shift_a: assert property (tck_rise && !tap_rst && state == TS_SH_IR
    |=> ir_sh == {$past(tdi_s), $past(ir_sh[IR_W-1:1])}) // RULE2
    else $error("Instruction shift wrong");
  tdo_fall_a: assert property (!test_off && $changed(tdo_out) |-> $past(tck_fall)) // RULE15
    else $error("TDO changed off a TCK fall");
  tms_step_a: assert property (tck_rise && !tap_rst && state == TS_IDLE && tms_s |=> state == TS_SEL_DR) // RULE15
    else $error("Wrong step from idle");
  dbg_drive_a: assert property (dbg_ok && dbg_out_en_in && breakpoint_in |=> dbg_pin_oe_out && !dbg_pin_out) // RULE6
    else $error("Debug pin not pulled on breakpoint");
  dbg_float_a: assert property (!dbg_out_en_in |=> !dbg_pin_oe_out) // RULE6
    else $error("Debug pin driven while output disabled");
  dbg_input_a: assert property (dbg_ok && dbg_in_en_in && !dbg_s |=> debug_req_out) // RULE7
    else $error("Debug request missed");
  boot_lock_a: assert property ($rose(boot_go) |-> $past(pll_s)) // RULE11
    else $error("Boot started without lock");
  chip_sel_a: assert property (sel_chip && !tap_rst |=> inner_out.sel) // RULE3
    else $error("Inner TAP not selected");

  id_read_c: cover property (sel_id && state == TS_SH_DR ##1 state == TS_EX1_DR);
  chip_path_c: cover property (inner_out.sel && tck_rise);
  dbg_break_c: cover property ($rose(dbg_pin_oe_out));
  boot_c: cover property ($rose(boot_go));

endmodule

// File: logic/jtd_pkg.sv
// Shared constants, instruction codes, TAP states and pin bundles for the test port
package jtd_pkg;

  // Register widths
  localparam int IR_W = 4;
  localparam int DR_W = 32;

  // Instruction codes
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_DEVICE_IDENTIFICATION_WORD = 4'h2;
  localparam logic [3:0] INS_USERCODE = 4'h3;
  localparam logic [3:0] INS_CHIPTAP = 4'h4;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  // Fixed pattern loaded into the instruction shifter on capture
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identification word fields, bit 31 down to 0
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;

  // User code word fields
  localparam int UC_UID_LSB = 22;
  localparam int UC_UID_W = 10;
  localparam int UC_REV_W = 16;

  // Security register bits
  localparam int SEC_TEST_OFF = 0;
  localparam int SEC_DBG_OFF = 14;
  localparam int SEC_UID_LSB = 22;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;

  // Sixteen standard TAP states
  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR, TS_UPD_DR,
    TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
  } jtd_state_t;

  // Test port pins as they arrive from the host
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtd_pins_t;

  // Pins that go on to the inner chip TAP
  typedef struct packed {
    logic sel;
    logic tck;
    logic tms;
    logic tdi;
  } jtd_inner_t;

endpackage

// File: verification/jtd_host.sv
// Host model that drives the test port pins and reads the serial answer
`timescale 1ns/10ps
module jtd_host import jtd_pkg::*; (
  // Clock
  input wire logic clk_in,
  // Test port pins
  output jtd_pins_t pins_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  logic oe_seen;
  logic last;
  // Power-up with test reset low; the bench releases it well past 100 ns
  initial begin
    pins_out = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
    oe_seen = 1'b0;
    last = 1'b0;
  end
  // Level of the test reset pin
  task automatic set_trst(input logic v);
    pins_out.trst_n = v;
  endtask
  // One TCK period: data set while low, answer taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    pins_out.tms = tms;
    pins_out.tdi = tdi;
    repeat (8) @(negedge clk_in);
    last = tdo_oe_in ? tdo_in : ~last; // Released line shows no stale value
    tdo = last;
    oe_seen = oe_seen | tdo_oe_in;
    pins_out.tck = 1'b1;
    repeat (8) @(negedge clk_in);
    pins_out.tck = 1'b0;
  endtask
  // Five ones reach reset from any state, then park in idle
  task automatic tap_reset;
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  // Idle to idle through one scan, LSB first, last bit leaves shift
  task automatic scan(input logic ir_sel, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    oe_seen = 1'b0;
    step(1'b1, 1'b0, b);
    if (ir_sel) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the test port block
`timescale 1ns/10ps
module testbench;
  import jtd_pkg::*;
  // Identity values are arbitrary
  localparam logic [3:0] VER = 4'h2;
  localparam logic [15:0] PART = 16'h1357;
  localparam logic [10:0] MFR = 11'h2a5;
  localparam logic [15:0] REV = 16'h0042;
  logic clk, rstn, tdo, tdo_oe, inner_tdo, dbg_pin, dbg_drv, dbg_oe;
  logic out_en, in_en, bp, dbg_req, lock, boot_go, ext_low;
  logic [7:0] core_o, pad_i, pad_o;
  logic [31:0] sec;
  logic [2:0] mode_i, mode_o;
  jtd_pins_t pins;
  jtd_inner_t inner;
  int fails, total_checks, cycles;
  // Open-drain debug pin with pull-up
  assign dbg_pin = !((dbg_oe && !dbg_drv) || ext_low);
  jtd_tap #(.BSC_N(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .SI_REV(REV), .BOOT_MODE_W(3)) u_jtd_tap (
    .clk_in(clk), .rstn_in(rstn), .pins_in(pins), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .inner_out(inner), .inner_tdo_in(inner_tdo), .core_out_in(core_o), .pad_in(pad_i), .pad_out(pad_o),
    .dbg_pin_in(dbg_pin), .dbg_pin_out(dbg_drv), .dbg_pin_oe_out(dbg_oe), .dbg_out_en_in(out_en),
    .dbg_in_en_in(in_en), .breakpoint_in(bp), .debug_req_out(dbg_req), .sec_word_in(sec),
    .pll_lock_in(lock), .boot_mode_in(mode_i), .boot_go_out(boot_go), .boot_mode_out(mode_o));
  jtd_host u_jtd_host (.clk_in(clk), .pins_out(pins), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
  always #5 clk = ~clk;
  // Hang guard, about three and a half times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 24000) begin
      fails++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ir(input logic [3:0] code);
    logic [31:0] d;
    u_jtd_host.scan(1'b1, 4, {28'h0, code}, d);
    chk(d[3:0], IR_CAPTURE);
  endtask
  task automatic dr(input logic [31:0] din, output logic [31:0] dout);
    u_jtd_host.scan(1'b0, 32, din, dout);
  endtask
  // Scans while test reset is low must never drive the data out
  task automatic t_trst;
    logic [31:0] d;
    dr(32'h0, d);
    chk(u_jtd_host.oe_seen, 1'b0);
    u_jtd_host.set_trst(1'b1);
    repeat (4) @(negedge clk);
    u_jtd_host.tap_reset;
  endtask
  task automatic t_boot;
    repeat (10) @(negedge clk);
    chk(boot_go, 1'b0);
    mode_i = 3'h5;
    lock = 1'b1;
    repeat (4) @(negedge clk);
    chk({boot_go, mode_o}, 4'hd);
    mode_i = 3'h2;
    repeat (2) @(negedge clk);
    chk(mode_o, 3'h5);
  endtask
  // Identity word is the default path, then the user word
  task automatic t_id;
    logic [31:0] d;
    dr(32'h0, d);
    chk(d, {VER, PART, MFR, 1'b1});
    chk(u_jtd_host.oe_seen, 1'b1);
    ir(INS_USERCODE);
    dr(32'h0, d);
    chk(d, {sec[31:22], 6'h00, REV});
  endtask
  // Bypass and an unassigned code both give one cell of delay
  task automatic t_bypass;
    logic [31:0] d;
    logic [3:0] c [2] = '{INS_BYPASS, 4'h7};
    for (int i = 0; i < 2; i++) begin
      ir(c[i]);
      dr(32'h8765_4321, d);
      chk(d, 32'h0eca_8642);
    end
  endtask
  task automatic t_bscan;
    logic [31:0] d;
    pad_i = 8'h5a;
    core_o = 8'h3c;
    ir(INS_SAMPLE);
    dr(32'hc300_0000, d);
    chk({d[7:0], pad_o}, 16'h5a3c);
    ir(INS_EXTEST);
    chk(pad_o, 8'hc3);
    ir(INS_BYPASS);
    chk(pad_o, 8'h3c);
  endtask
  task automatic t_chip;
    logic [31:0] d;
    inner_tdo = 1'b1;
    ir(INS_CHIPTAP);
    chk(inner.sel, 1'b1);
    repeat (4) @(negedge clk);
    chk(inner, 4'h8);
    dr(32'h0, d);
    chk(d, 32'hffff_ffff);
    inner_tdo = 1'b0;
    dr(32'hffff_ffff, d);
    chk(d, 32'h0);
    ir(INS_BYPASS);
    chk({inner.sel, inner.tms}, 2'h1);
  endtask
  task automatic t_dbg;
    chk(dbg_pin, 1'b1);
    bp = 1'b1;
    repeat (4) @(negedge clk);
    chk(dbg_oe, 1'b0);
    out_en = 1'b1;
    repeat (4) @(negedge clk);
    chk({dbg_oe, dbg_pin}, 2'h2);
    bp = 1'b0;
    repeat (4) @(negedge clk);
    chk(dbg_oe, 1'b0);
    ext_low = 1'b1;
    repeat (5) @(negedge clk);
    chk(dbg_req, 1'b0);
    in_en = 1'b1;
    repeat (5) @(negedge clk);
    chk(dbg_req, 1'b1);
    ext_low = 1'b0;
    repeat (5) @(negedge clk);
    chk(dbg_req, 1'b0);
  endtask
  // Mid-run reset with the port and debug pin locked off
  task automatic t_secure;
    logic [31:0] d;
    sec = 32'h0000_4001;
    rstn = 1'b0;
    #1;
    chk(boot_go, 1'b0);
    // Global reset stays low for at least 100 ns
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    u_jtd_host.tap_reset;
    dr(32'h0, d);
    chk(u_jtd_host.oe_seen, 1'b0);
    bp = 1'b1;
    repeat (4) @(negedge clk);
    chk(dbg_oe, 1'b0);
  endtask
  initial begin
    {clk, rstn, inner_tdo, out_en, in_en, bp, lock, ext_low} = '0;
    {core_o, pad_i, mode_i, fails, total_checks, cycles} = '0;
    sec = 32'hb640_0000;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_trst;
    t_boot;
    t_id;
    t_bypass;
    t_bscan;
    t_chip;
    t_dbg;
    t_secure;
    report_and_stop;
  end
endmodule
